// ### common/psc_pkg.sv
package psc_pkg;
    // apb register byte offsets
    localparam logic [7:0] PSC_CTRL_OFS = 8'h00;
    localparam logic [7:0] PSC_CMD_OFS = 8'h04;
    localparam logic [7:0] PSC_OPT_OFS = 8'h08;
    localparam logic [7:0] PSC_STAT_OFS = 8'h0C;
    // ctrl fields
    localparam int PSC_CTRL_ILK_EN = 0;
    localparam int PSC_CTRL_SEL_LO = 1;
    localparam logic [1:0] PSC_CTRL_SEL_RST = 2'h0;
    // cmd fields, write-one pulses
    localparam int PSC_CMD_START = 0;
    localparam int PSC_CMD_STOP = 1;
    localparam int PSC_CMD_CLEAR = 2;
    localparam int PSC_CMD_LOCK = 3;
    localparam int PSC_CMD_UNLOCK = 4;
    // over power trip scaling: full scale and 110 percent ceiling
    localparam int PSC_PWR_W = 16;
    localparam logic [31:0] PSC_PWR_FULL = 32'h0000_8000;
    localparam logic [31:0] PSC_OPT_PCT = 32'h0000_006E;
    localparam logic [31:0] PSC_PCT_DIV = 32'h0000_0064;
    localparam logic [31:0] PSC_OPT_MAX32 = (PSC_PWR_FULL * PSC_OPT_PCT) / PSC_PCT_DIV;
    localparam logic [PSC_PWR_W-1:0] PSC_OPT_MAX = PSC_OPT_MAX32[PSC_PWR_W-1:0];
    // consecutive samples before an over power fault registers
    localparam logic [2:0] PSC_OPT_SAMPLES = 3'h4;
    localparam int PSC_NUM_DIN = 4;
    localparam int PSC_NUM_AIN = 4;
    // status codes
    typedef enum logic [1:0] {
        PSC_ENABLED = 2'b00,
        PSC_DISABLED = 2'b01,
        PSC_SOFT = 2'b10,
        PSC_HARD = 2'b11
    } psc_state_t;
    // front panel button pulses
    typedef struct packed {
        logic start;
        logic stop;
        logic clear;
        logic lock;
    } psc_panel_t;
    // status word as read back
    typedef struct packed {
        logic [20:0] rsvd;
        logic power_on;
        logic lock_pan;
        logic lock_rem;
        logic lock_din;
        logic lock_led;
        logic thermal;
        logic ilk_fault;
        logic uio_alarm;
        logic opt_alarm;
        psc_state_t state;
    } psc_stat_t;
endpackage : psc_pkg

// ### verilog/psc_top.sv
// Function
// [R1] trip threshold capped at 110 percent
// [R2] trip only after consecutive over samples
// [R3] over power opens switch, latches alarm
// [R4] recovery: below threshold, clear, then start
// [R5] threshold resets to 110 percent
// [R6] thermal forces hard fault, blocks enable
// [R7] hard fault left only by reset
// [R8] enabled interlock loss gives soft fault
// [R9] interlock disabled by default, software enables
// [R10] interlock restored before clear is accepted
// [R11] lock ignores panel except stop; led
// [R12] lock sources ranked din, remote, panel
// [R13] digital input lock released only by input
// [R14] alarm on user input over range
// [R15] user alarm latches; range, clear, start
// [R16] power on: rocker and jumper or estop
// [R17] default jumper fitted, rocker alone decides
// [R18] enabled engages input; disabled waits start
// [R19] clear moves soft fault to disabled
// [R20] switch open outside enabled
// [R21] status readable on bus and pins
// [R22] two-bit status code, clocked
//
// Added by the designer: the APB slave port and the address map.
module psc_top
    import psc_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // power measurement
    input wire logic [PSC_PWR_W-1:0] pwr_sample,
    input wire logic pwr_valid,
    // fault and lock sources
    input wire logic thermal_fault,
    input wire logic [PSC_NUM_DIN-1:0] dig_in,
    input wire logic [PSC_NUM_DIN-1:0] din_over,
    input wire logic [PSC_NUM_AIN-1:0] ain_over,
    input wire logic lock_din,
    // front panel
    input wire psc_panel_t panel,
    // power circuit
    input wire logic rocker_on,
    input wire logic estop_bypass_jumper,
    input wire logic estop_24v,
    // outputs
    output logic input_engaged,
    output psc_state_t status_code,
    output logic lock_led,
    output logic opt_alarm,
    output logic uio_alarm,
    output logic product_power_on
);

    psc_state_t state_reg, state_next;
    logic [31:0] prdata_reg;
    logic pready_reg, pslverr_reg;
    logic ilk_en_reg;
    logic [1:0] ilk_sel_reg;
    logic [PSC_PWR_W-1:0] opt_thr_reg;
    logic [2:0] opt_cnt_reg;
    logic opt_over_reg;
    logic opt_alarm_reg, uio_alarm_reg, ilk_fault_reg;
    logic lk_din_reg, lk_rem_reg, lk_pan_reg;
    logic lk_din_next, lk_rem_next, lk_pan_next;
    logic din_prev_reg;
    logic engaged_reg, lock_led_reg, power_on_reg;
    logic [4:0] cmd_reg;
    logic wr_en, setup;
    logic locked, start_cmd, stop_cmd, clear_cmd, clear_ok;
    logic opt_trip, uio_now, ilk_now, soft_evt;
    psc_stat_t stat;

    // bus strobes
    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pready_reg & pwrite;

    // status word assembly
    always_comb begin
        stat = '0;
        stat.state = state_reg; // [R21]
        stat.opt_alarm = opt_alarm_reg;
        stat.uio_alarm = uio_alarm_reg;
        stat.ilk_fault = ilk_fault_reg;
        stat.thermal = (state_reg == PSC_HARD);
        stat.lock_led = lock_led_reg;
        stat.lock_din = lk_din_reg;
        stat.lock_rem = lk_rem_reg;
        stat.lock_pan = lk_pan_reg;
        stat.power_on = power_on_reg;
    end

    // apb answer: one access cycle, read data latched at setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= setup;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            if (setup) begin
                case (paddr)
                    PSC_CTRL_OFS: prdata_reg <= {29'h0, ilk_sel_reg, ilk_en_reg};
                    PSC_CMD_OFS: prdata_reg <= 32'h0000_0000;
                    PSC_OPT_OFS: prdata_reg <= {16'h0000, opt_thr_reg};
                    PSC_STAT_OFS: prdata_reg <= stat;
                    default: pslverr_reg <= 1'b1;
                endcase
            end
        end
    end

    // configuration: interlock enable and pin select
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ilk_en_reg <= 1'b0; // [R9]
            ilk_sel_reg <= PSC_CTRL_SEL_RST;
        end else if (wr_en && paddr == PSC_CTRL_OFS) begin
            ilk_en_reg <= pwdata[PSC_CTRL_ILK_EN]; // [R9]
            ilk_sel_reg <= pwdata[PSC_CTRL_SEL_LO +: 2];
        end
    end

    // trip threshold, clamped to the ceiling
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opt_thr_reg <= PSC_OPT_MAX; // [R5]
        end else if (wr_en && paddr == PSC_OPT_OFS) begin
            if (pwdata[PSC_PWR_W-1:0] > PSC_OPT_MAX) begin
                opt_thr_reg <= PSC_OPT_MAX; // [R1]
            end else begin
                opt_thr_reg <= pwdata[PSC_PWR_W-1:0];
            end
        end
    end

    // remote command pulses, one cycle after the write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_reg <= 5'h00;
        end else if (wr_en && paddr == PSC_CMD_OFS) begin
            cmd_reg <= pwdata[4:0];
        end else begin
            cmd_reg <= 5'h00;
        end
    end

    // consecutive over power sample counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opt_cnt_reg <= 3'h0;
            opt_over_reg <= 1'b0;
        end else if (pwr_valid) begin
            opt_over_reg <= (pwr_sample > opt_thr_reg);
            if (pwr_sample <= opt_thr_reg) begin
                opt_cnt_reg <= 3'h0; // [R2]
            end else if (opt_cnt_reg != PSC_OPT_SAMPLES) begin
                opt_cnt_reg <= opt_cnt_reg + 3'h1; // [R2]
            end
        end
    end

    // fault conditions
    assign opt_trip = (opt_cnt_reg == PSC_OPT_SAMPLES); // [R2]
    assign uio_now = (|din_over) | (|ain_over); // [R14]
    assign ilk_now = ilk_en_reg & ~dig_in[ilk_sel_reg]; // [R8]
    assign soft_evt = opt_trip | uio_now | ilk_now;

    // command sources; panel stop acts even while locked
    assign locked = lk_din_reg | lk_rem_reg | lk_pan_reg;
    assign start_cmd = cmd_reg[PSC_CMD_START] | (panel.start & ~locked); // [R11]
    assign stop_cmd = cmd_reg[PSC_CMD_STOP] | panel.stop; // [R11]
    assign clear_cmd = cmd_reg[PSC_CMD_CLEAR] | (panel.clear & ~locked); // [R11]
    // clear accepted only once every cause is gone
    assign clear_ok = clear_cmd & (state_reg == PSC_SOFT) & ~soft_evt & ~opt_over_reg; // [R4] [R10] [R15]

    // latched alarm flags; a new event wins over a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opt_alarm_reg <= 1'b0;
            uio_alarm_reg <= 1'b0;
            ilk_fault_reg <= 1'b0;
        end else begin
            if (opt_trip) begin
                opt_alarm_reg <= 1'b1; // [R3]
            end else if (clear_ok) begin
                opt_alarm_reg <= 1'b0; // [R4]
            end
            if (uio_now) begin
                uio_alarm_reg <= 1'b1; // [R15]
            end else if (clear_ok) begin
                uio_alarm_reg <= 1'b0; // [R15]
            end
            if (ilk_now) begin
                ilk_fault_reg <= 1'b1; // [R8]
            end else if (clear_ok) begin
                ilk_fault_reg <= 1'b0; // [R10]
            end
        end
    end

    // status state machine
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            PSC_ENABLED: begin
                if (soft_evt) begin
                    state_next = PSC_SOFT; // [R3] [R8] [R15]
                end else if (stop_cmd) begin
                    state_next = PSC_DISABLED;
                end
            end
            PSC_DISABLED: begin
                if (soft_evt) begin
                    state_next = PSC_SOFT;
                end else if (start_cmd) begin
                    state_next = PSC_ENABLED; // [R4] [R18]
                end
            end
            PSC_SOFT: begin
                if (clear_ok) begin
                    state_next = PSC_DISABLED; // [R19]
                end
            end
            PSC_HARD: state_next = PSC_HARD; // [R7]
            default: state_next = PSC_DISABLED;
        endcase
        if (thermal_fault) begin
            state_next = PSC_HARD; // [R6] [R7]
        end
    end

    // state register, code updated on the clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= PSC_DISABLED;
        end else begin
            state_reg <= state_next; // [R22]
        end
    end

    // disconnect switch closed only when enabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            engaged_reg <= 1'b0;
        end else begin
            engaged_reg <= (state_next == PSC_ENABLED); // [R6] [R18] [R20]
        end
    end

    // lock arbitration by source rank
    always_comb begin
        lk_din_next = lk_din_reg;
        lk_rem_next = lk_rem_reg;
        lk_pan_next = lk_pan_reg;
        if (panel.lock) begin
            if (!locked) begin
                lk_pan_next = 1'b1;
            end else if (!lk_din_reg && !lk_rem_reg) begin
                lk_pan_next = 1'b0; // [R12]
            end
        end
        if (cmd_reg[PSC_CMD_LOCK]) begin
            lk_rem_next = 1'b1;
        end else if (cmd_reg[PSC_CMD_UNLOCK]) begin
            lk_rem_next = 1'b0; // [R12]
            lk_pan_next = 1'b0;
        end
        if (lock_din && !din_prev_reg) begin
            lk_din_next = 1'b1;
        end else if (!lock_din && din_prev_reg) begin
            lk_din_next = 1'b0; // [R13]
            lk_rem_next = 1'b0;
            lk_pan_next = 1'b0;
        end
    end

    // lock registers and indicator
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lk_din_reg <= 1'b0;
            lk_rem_reg <= 1'b0;
            lk_pan_reg <= 1'b0;
            din_prev_reg <= 1'b0;
            lock_led_reg <= 1'b0;
        end else begin
            lk_din_reg <= lk_din_next; // [R13]
            lk_rem_reg <= lk_rem_next;
            lk_pan_reg <= lk_pan_next;
            din_prev_reg <= lock_din;
            lock_led_reg <= lk_din_next | lk_rem_next | lk_pan_next; // [R11]
        end
    end

    // product power from rocker, jumper and estop level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_on_reg <= 1'b0;
        end else begin
            power_on_reg <= rocker_on & (estop_bypass_jumper | estop_24v); // [R16] [R17]
        end
    end

    // outputs
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign input_engaged = engaged_reg;
    assign status_code = state_reg; // [R21]
    assign lock_led = lock_led_reg;
    assign opt_alarm = opt_alarm_reg;
    assign uio_alarm = uio_alarm_reg;
    assign product_power_on = power_on_reg;

endmodule : psc_top

// ### tb/psc_props.sv
module psc_props
    import psc_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // causes
    input wire logic thermal_fault,
    input wire logic [PSC_NUM_DIN-1:0] din_over,
    input wire logic [PSC_NUM_AIN-1:0] ain_over,
    input wire logic lock_din,
    input wire psc_panel_t panel,
    input wire logic rocker_on,
    input wire logic estop_bypass_jumper,
    input wire logic estop_24v,
    // results
    input wire logic input_engaged,
    input wire psc_state_t status_code,
    input wire logic lock_led,
    input wire logic opt_alarm,
    input wire logic uio_alarm,
    input wire logic product_power_on
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // switch closed exactly while enabled
    chk_engage_match: assert property (input_engaged == (status_code == PSC_ENABLED))
        else $error("engage and status disagree");
    chk_thermal_hard: assert property (thermal_fault |=> status_code == PSC_HARD)
        else $error("thermal without hard fault");
    chk_hard_holds: assert property (status_code == PSC_HARD |=> status_code == PSC_HARD)
        else $error("hard fault left");
    chk_power_eq: assert property (1'b1 |=> product_power_on == $past(rocker_on && (estop_bypass_jumper || estop_24v)))
        else $error("power state wrong");
    chk_opt_trip: assert property ($rose(opt_alarm) |-> status_code == PSC_SOFT && !input_engaged)
        else $error("trip without soft fault");
    chk_soft_exit: assert property (status_code == PSC_SOFT ##1 status_code != PSC_SOFT
        |-> status_code inside {PSC_DISABLED, PSC_HARD})
        else $error("soft fault left wrongly");
    chk_start_path: assert property ($rose(input_engaged) |-> $past(status_code) == PSC_DISABLED)
        else $error("engaged from wrong status");
    chk_uio_trip: assert property ((|din_over || |ain_over) && status_code != PSC_HARD
        |=> uio_alarm && !input_engaged)
        else $error("over range not latched");
    chk_din_lock: assert property ($rose(lock_din) |=> lock_led)
        else $error("input lock not shown");
    chk_panel_locked: assert property (lock_led && panel.start && !input_engaged |=> !input_engaged)
        else $error("panel start acted while locked");
    // main scenarios
    cover property ($rose(opt_alarm));
    cover property (status_code == PSC_HARD);
    cover property (lock_led && lock_din);
endmodule : psc_props

bind psc_top psc_props i_props (
    .pclk(pclk), .presetn(presetn), .thermal_fault(thermal_fault), .din_over(din_over),
    .ain_over(ain_over), .lock_din(lock_din), .panel(panel), .rocker_on(rocker_on),
    .estop_bypass_jumper(estop_bypass_jumper), .estop_24v(estop_24v), .input_engaged(input_engaged),
    .status_code(status_code), .lock_led(lock_led), .opt_alarm(opt_alarm), .uio_alarm(uio_alarm),
    .product_power_on(product_power_on)
);

// ### tb/psc_far_side.sv
module psc_far_side
    import psc_pkg::*;
(
    // clock
    input wire logic pclk,
    // front panel buttons
    output psc_panel_t panel
);
    timeunit 1ns;
    timeprecision 1ns;
    initial panel = '0;
    // one-cycle button pulse, launched just after an edge
    task automatic press(input psc_panel_t b);
        @(posedge pclk);
        panel <= b;
        @(posedge pclk);
        panel <= '0;
    endtask : press
endmodule : psc_far_side

// ### tb/psc_top_tb_top.sv
module psc_top_tb_top
    import psc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pwr_valid = 0;
    logic thermal_fault = 0, lock_din = 0, rocker_on = 1, estop_bypass_jumper = 1, estop_24v = 0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic pready, pslverr, input_engaged, lock_led, opt_alarm, uio_alarm, product_power_on;
    logic [15:0] pwr_sample = '0, thr;
    logic [3:0] dig_in = '1, din_over = '0, ain_over = '0;
    logic [65:0] x;
    logic [65:0] q[$];
    psc_panel_t panel;
    psc_state_t status_code;
    int n_errors = 0, num_checks = 0, cyc = 0;

    psc_far_side i_far (.pclk(pclk), .panel(panel));
    psc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pwr_sample(pwr_sample), .pwr_valid(pwr_valid), .thermal_fault(thermal_fault), .dig_in(dig_in),
        .din_over(din_over), .ain_over(ain_over), .lock_din(lock_din), .panel(panel), .rocker_on(rocker_on),
        .estop_bypass_jumper(estop_bypass_jumper), .estop_24v(estop_24v), .input_engaged(input_engaged),
        .status_code(status_code), .lock_led(lock_led), .opt_alarm(opt_alarm), .uio_alarm(uio_alarm),
        .product_power_on(product_power_on));

    always #50 pclk = ~pclk;

    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize

    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    // apb transfer, held until pready is seen at an edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        repeat (3) @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 0;
        penable <= 0;
    endtask : xfer

    // read with expectation noted; slave error always compared
    task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
        q.push_back({m | 33'h1_0000_0000, e});
        xfer(0, a, '0);
    endtask : rd

    task automatic st(input logic [32:0] e);
        rd(PSC_STAT_OFS, e, 33'h7F);
    endtask : st

    task automatic cmd(input int b);
        xfer(1, PSC_CMD_OFS, 32'h1 << b);
    endtask : cmd

    // n consecutive valid power samples
    task automatic smp(input logic [15:0] v, input int n);
        repeat (n) begin
            @(posedge pclk);
            pwr_valid <= 1;
            pwr_sample <= v;
        end
        @(posedge pclk);
        pwr_valid <= 0;
    endtask : smp

    task automatic rst();
        presetn <= 0;
        repeat (10) @(posedge pclk);
        presetn <= 1;
    endtask : rst

    // read monitor and run limit
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (psel && penable && pready && !pwrite) begin
            x = q.pop_front();
            chk({pslverr, prdata} & x[65:33], x[32:0]);
        end
        if (cyc == 20000) begin
            n_errors++;
            summarize();
        end
    end

    initial begin
        void'($urandom(32'h8728));
        thr = 16'h0100 + 16'($urandom % 32'h7000);
        repeat (10) @(posedge pclk);
        presetn <= 1;
        rd(PSC_CTRL_OFS, 33'h0, 33'h7);
        rd(PSC_OPT_OFS, 33'h8CCC, 33'hFFFF);
        rd(PSC_STAT_OFS, 33'h401, 33'h47F);
        rd(8'h10, 33'h1_0000_0000, 33'h1_FFFF_FFFF);
        xfer(1, PSC_OPT_OFS, 32'hFFFF);
        rd(PSC_OPT_OFS, 33'h8CCC, 33'hFFFF);
        xfer(1, PSC_OPT_OFS, {16'h0, thr});
        rd(PSC_OPT_OFS, {17'h0, thr}, 33'hFFFF);
        cmd(PSC_CMD_START);
        st(33'h0);
        smp(thr + 16'h1, 3);
        smp(thr, 1);
        smp(thr + 16'h1, 3);
        st(33'h0);
        smp(thr + 16'h1, 1);
        st(33'h6);
        cmd(PSC_CMD_CLEAR);
        st(33'h6);
        smp(thr, 1);
        cmd(PSC_CMD_CLEAR);
        st(33'h1);
        cmd(PSC_CMD_START);
        st(33'h0);
        xfer(1, PSC_CTRL_OFS, 32'h5);
        dig_in <= 4'h4;
        st(33'h0);
        dig_in <= 4'h0;
        st(33'h12);
        cmd(PSC_CMD_CLEAR);
        st(33'h12);
        dig_in <= 4'hF;
        cmd(PSC_CMD_CLEAR);
        st(33'h1);
        for (int k = 0; k < 2; k++) begin
            cmd(PSC_CMD_START);
            din_over <= k ? 4'h0 : 4'h2;
            ain_over <= k ? 4'h8 : 4'h0;
            st(33'hA);
            cmd(PSC_CMD_CLEAR);
            st(33'hA);
            din_over <= '0;
            ain_over <= '0;
            cmd(PSC_CMD_CLEAR);
            st(33'h1);
        end
        i_far.press(psc_panel_t'(4'h1));
        rd(PSC_STAT_OFS, 33'h241, 33'h3FF);
        i_far.press(psc_panel_t'(4'h8));
        st(33'h41);
        cmd(PSC_CMD_START);
        st(33'h40);
        i_far.press(psc_panel_t'(4'h4));
        st(33'h41);
        cmd(PSC_CMD_LOCK);
        lock_din <= 1;
        cmd(PSC_CMD_UNLOCK);
        rd(PSC_STAT_OFS, 33'h0C0, 33'h3C0);
        lock_din <= 0;
        i_far.press(psc_panel_t'(4'h1));
        cmd(PSC_CMD_LOCK);
        i_far.press(psc_panel_t'(4'h1));
        rd(PSC_STAT_OFS, 33'h340, 33'h3C0);
        cmd(PSC_CMD_UNLOCK);
        rd(PSC_STAT_OFS, 33'h0, 33'h3C0);
        for (int i = 0; i < 8; i++) begin
            {estop_24v, rocker_on, estop_bypass_jumper} <= 3'(i);
            rd(PSC_STAT_OFS, {22'h0, i[1] && (i[0] || i[2]), 10'h0}, 33'h400);
        end
        thermal_fault <= 1;
        st(33'h23);
        cmd(PSC_CMD_CLEAR);
        cmd(PSC_CMD_START);
        i_far.press(psc_panel_t'(4'h8));
        thermal_fault <= 0;
        rd(PSC_STAT_OFS, 33'h3, 33'h3);
        thermal_fault <= 1;
        rst();
        rd(PSC_STAT_OFS, 33'h3, 33'h3);
        thermal_fault <= 0;
        rst();
        st(33'h1);
        rd(PSC_OPT_OFS, 33'h8CCC, 33'hFFFF);
        summarize();
    end
endmodule : psc_top_tb_top
